// [verilog/tqt_regs.vh]
// Register map, fields and reset values of the trace qualifier.
// Included by the qualifier and top-level design files.
`ifndef TQT_REGS_VH
`define TQT_REGS_VH

`define TQT_CTRL        10'h000
`define TQT_TPOS        10'h004
`define TQT_LOOP        10'h008
`define TQT_STATUS      10'h00C
`define TQT_IRQ_STAT    10'h010
`define TQT_IRQ_ENA     10'h014
`define TQT_IRQ_CLR     10'h018
`define TQT_CMD         10'h01C
`define TQT_COUNT       10'h020
`define TQT_Q_BASE_BIT  9
`define TQT_Q_NUM       20
`define TQT_Q_PER_GROUP 10

`define TQT_W_CTL       2'h0
`define TQT_W_ADDR      2'h1
`define TQT_W_MISC      2'h2
`define TQT_W_PORT      2'h3

`define TQT_QC_ACTIVE   0
`define TQT_QC_RANGE    1

`define TQT_M_FETCH     15
`define TQT_M_WRITE     14
`define TQT_M_READ      13
`define TQT_M_PROBE1    12
`define TQT_M_PROBE0    11

`define TQT_SEL_ALL     2'h0
`define TQT_SEL_A       2'h1
`define TQT_SEL_B       2'h2
`define TQT_SEL_AB      2'h3
`define TQT_INT_ALL     2'h0
`define TQT_INT_MAIN    2'h1
`define TQT_INT_ONLY    2'h2

`define TQT_C_CAP       1:0
`define TQT_C_TRIGGER_SELECT      3:2
`define TQT_C_INT       5:4
`define TQT_C_BRK       6

`define TQT_IRQ_TRIGGER_SELECT    0
`define TQT_IRQ_DONE    1
`define TQT_IRQ_BRK     2

`define TQT_DEPTH       15'h4000
`define TQT_TPOS_RST    15'h2000
`define TQT_LOOP_RST    16'h0000

`endif

// [verilog/tqt_sync.v]
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes asynchronous pins and a single system clock.
`timescale 1ns/10ps
`default_nettype none

module tqt_sync #(
    parameter W = 2
) (
    input  wire         clk_sys_i,
    input  wire         reset_n_i,
    input  wire [W-1:0] pin_i,
    output wire [W-1:0] level_o
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    reg [W-1:0] lvl_reg;
    integer     i;

    // Level moves only when stages two and three agree
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            s1_reg  <= {W{1'b0}};
            s2_reg  <= {W{1'b0}};
            s3_reg  <= {W{1'b0}};
            lvl_reg <= {W{1'b0}};
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    lvl_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    assign level_o = lvl_reg;
endmodule

`default_nettype wire

// [verilog/tqt_qual.v]
// One qualifier register comparator, purely combinational.
// Assumes all inputs come from the system clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "tqt_regs.vh"

module tqt_qual (
    input  wire [1:0]  ctl_i,
    input  wire [31:0] addr_w_i,
    input  wire [31:0] misc_w_i,
    input  wire [31:0] port_w_i,
    input  wire [15:0] f_addr_i,
    input  wire [15:0] f_misc_i,
    input  wire [7:0]  f_p1_i,
    input  wire [7:0]  f_p3_i,
    output wire        match_o
);
    wire addr_ok;
    wire misc_ok;
    wire port_ok;
    wire in_range;
    wire by_mask;

    assign in_range = (f_addr_i >= addr_w_i[15:0])
                    && (f_addr_i <= addr_w_i[31:16]);
    assign by_mask  = ((f_addr_i ^ addr_w_i[15:0]) & addr_w_i[31:16])
                    == 16'h0000; // RQ13
    assign addr_ok  = ctl_i[`TQT_QC_RANGE] ? in_range : by_mask; // RQ9
    assign misc_ok  = ((f_misc_i ^ misc_w_i[15:0]) & misc_w_i[31:16])
                    == 16'h0000; // RQ10
    assign port_ok  = (({f_p3_i, f_p1_i} ^ port_w_i[15:0])
                    & port_w_i[31:16]) == 16'h0000;
    assign match_o  = ctl_i[`TQT_QC_ACTIVE] & addr_ok
                    & misc_ok & port_ok; // RQ8 RQ14
endmodule

`default_nettype wire

// [verilog/tqt_top.v]
// Trace qualifier and trigger unit with an Avalon-MM register slave.
// Assumes frame inputs are on clk_sys_i; probe pins are asynchronous.
// What this block does
// RQ1 - Capture filter can store only frames meeting a qualifier condition
// RQ2 - Capture filter condition comes from group A or group B
// RQ3 - Trigger select picks qualifier function or none to start trigger
// RQ4 - Separate filter decides whether interrupt service frames get stored
// RQ5 - Trigger position count splits pre/post frames, default half depth
// RQ6 - Loop count picks which trigger starts capture; zero means first
// RQ7 - One break enable makes all active qualifiers halt emulation
// RQ8 - Each qualifier has an activation bit; inactive ones never match
// RQ9 - Address matches a masked value or an inclusive range
// RQ10 - Cycle attribute bits qualify frame conditions beside the address
// RQ11 - Attribute bits: fetch 15, write 14, read 13, probes, level
// RQ12 - Ten qualifiers in group A and ten in group B, index 0..9
// RQ13 - Every qualifier bit is don't-care, must-be-high or must-be-low
// RQ14 - Match needs address, attributes, level, data and ports together
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tqt_regs.vh"

module tqt_top (
    input  wire        clk_sys_i,
    input  wire        reset_n_i,
    input  wire [9:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    input  wire        frame_valid_i,
    input  wire [15:0] frame_addr_i,
    input  wire [7:0]  frame_data_i,
    input  wire        first_opcode_fetch_flag_i,
    input  wire        frame_write_i,
    input  wire        frame_read_i,
    input  wire [2:0]  frame_int_level_i,
    input  wire        probe_input_one_i,
    input  wire        probe_input_zero_i,
    input  wire [7:0]  port_byte_one_i,
    input  wire [7:0]  port_byte_three_i,
    output wire        store_o,
    output wire        store_post_o,
    output wire        trigger_o,
    output wire        capturing_o,
    output wire        break_o,
    output wire        irq_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_PRE  = 4'b0010;
    localparam ST_POST = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg  [1:0]  q_ctl_reg  [0:`TQT_Q_NUM-1];
    reg  [31:0] q_addr_reg [0:`TQT_Q_NUM-1];
    reg  [31:0] q_misc_reg [0:`TQT_Q_NUM-1];
    reg  [31:0] q_port_reg [0:`TQT_Q_NUM-1];
    reg  [6:0]  ctrl_reg;
    reg  [14:0] tpos_reg;
    reg  [15:0] loop_reg;
    reg  [2:0]  irq_stat_reg;
    reg  [2:0]  irq_ena_reg;
    reg         ack_reg;
    reg  [31:0] rdata_reg;
    reg  [31:0] rdata_next;
    reg  [3:0]  state_reg;
    reg  [15:0] loop_cnt_reg;
    reg  [14:0] pre_cnt_reg;
    reg  [14:0] post_left_reg;
    reg         got_a_reg;
    reg         got_b_reg;
    reg         stopped_reg;
    reg         store_reg;
    reg         store_post_reg;
    reg         trigger_select_reg;
    reg         brk_reg;
    wire [1:0]  probes;
    wire [15:0] f_misc;
    wire [`TQT_Q_NUM-1:0] q_match;
    wire        any_a;
    wire        any_b;
    wire        int_ok;
    wire        cap_ok;
    wire        trigger_select_hit;
    wire        running;
    wire        wr_go;
    wire        q_sel;
    wire [4:0]  q_idx;
    wire [1:0]  q_word;
    wire        q_ok;
    wire        start_cmd;
    wire        stop_cmd;
    wire        fire;
    wire        last_post;
    wire [2:0]  irq_set;
    integer     k;
    genvar      g;

    // Selection code against the group hits
    function sel_hit;
        input [1:0] sel;
        input       a;
        input       b;
        begin
            case (sel)
                `TQT_SEL_A:  sel_hit = a;
                `TQT_SEL_B:  sel_hit = b;
                `TQT_SEL_AB: sel_hit = a | b;
                default:     sel_hit = 1'b0;
            endcase
        end
    endfunction

    tqt_sync #(
        .W(2)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .pin_i    ({probe_input_one_i, probe_input_zero_i}),
        .level_o  (probes)
    );

    // Attribute byte above the data byte
    assign f_misc = {first_opcode_fetch_flag_i, frame_write_i,
                     frame_read_i, probes, frame_int_level_i,
                     frame_data_i}; // RQ11

    generate
        for (g = 0; g < `TQT_Q_NUM; g = g + 1) begin : gen_q
            tqt_qual u_qual (
                .ctl_i   (q_ctl_reg[g]),
                .addr_w_i(q_addr_reg[g]),
                .misc_w_i(q_misc_reg[g]),
                .port_w_i(q_port_reg[g]),
                .f_addr_i(frame_addr_i),
                .f_misc_i(f_misc),
                .f_p1_i  (port_byte_one_i),
                .f_p3_i  (port_byte_three_i),
                .match_o (q_match[g])
            );
        end
    endgenerate

    // Group A is index 0..9, group B is index 10..19
    assign any_a = |q_match[`TQT_Q_PER_GROUP-1:0]; // RQ12
    assign any_b = |q_match[`TQT_Q_NUM-1:`TQT_Q_PER_GROUP]; // RQ12

    assign int_ok =
        (ctrl_reg[`TQT_C_INT] == `TQT_INT_MAIN) ?
            (frame_int_level_i == 3'h0) :
        (ctrl_reg[`TQT_C_INT] == `TQT_INT_ONLY) ?
            (frame_int_level_i != 3'h0) : 1'b1; // RQ4
    assign cap_ok = (ctrl_reg[`TQT_C_CAP] == `TQT_SEL_ALL)
                  | sel_hit(ctrl_reg[`TQT_C_CAP], any_a, any_b); // RQ1 RQ2
    assign trigger_select_hit = sel_hit(ctrl_reg[`TQT_C_TRIGGER_SELECT],
                              any_a, any_b); // RQ3
    assign running = state_reg[1] | state_reg[2];

    // Avalon slave: one wait state
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
    assign avs_readdata_o    = rdata_reg;
    assign wr_go  = avs_write_i & ack_reg;
    assign q_sel  = avs_address_i[`TQT_Q_BASE_BIT];
    assign q_idx  = avs_address_i[8:4];
    assign q_word = avs_address_i[3:2];
    assign q_ok   = q_sel & (q_idx < 5'h14);
    assign start_cmd = wr_go & (avs_address_i == `TQT_CMD)
                     & avs_writedata_i[0];
    assign stop_cmd  = wr_go & (avs_address_i == `TQT_CMD)
                     & avs_writedata_i[1];

    always @* begin
        rdata_next = 32'h00000000;
        if (q_ok) begin
            case (q_word)
                `TQT_W_CTL:  rdata_next = {30'h0, q_ctl_reg[q_idx]};
                `TQT_W_ADDR: rdata_next = q_addr_reg[q_idx];
                `TQT_W_MISC: rdata_next = q_misc_reg[q_idx];
                default:     rdata_next = q_port_reg[q_idx];
            endcase
        end else if (!q_sel) begin
            case (avs_address_i)
                `TQT_CTRL:     rdata_next = {25'h0, ctrl_reg};
                `TQT_TPOS:     rdata_next = {17'h0, tpos_reg};
                `TQT_LOOP:     rdata_next = {16'h0, loop_reg};
                `TQT_STATUS:   rdata_next = {8'h00, brk_reg, stopped_reg,
                                             got_b_reg, got_a_reg,
                                             state_reg, loop_cnt_reg};
                `TQT_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
                `TQT_IRQ_ENA:  rdata_next = {29'h0, irq_ena_reg};
                `TQT_COUNT:    rdata_next = {1'b0, post_left_reg,
                                             1'b0, pre_cnt_reg};
                default:       rdata_next = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= (avs_read_i | avs_write_i) & ~ack_reg;
            if (avs_read_i & ~ack_reg) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Setup registers
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= 7'h00;
            tpos_reg <= `TQT_TPOS_RST; // RQ5
            loop_reg <= `TQT_LOOP_RST;
            irq_ena_reg <= 3'h0;
            for (k = 0; k < `TQT_Q_NUM; k = k + 1) begin
                q_ctl_reg[k]  <= 2'h0; // RQ8
                q_addr_reg[k] <= 32'h00000000;
                q_misc_reg[k] <= 32'h00000000;
                q_port_reg[k] <= 32'h00000000;
            end
        end else if (wr_go) begin
            if (q_ok) begin
                case (q_word)
                    `TQT_W_CTL:  q_ctl_reg[q_idx]  <= avs_writedata_i[1:0];
                    `TQT_W_ADDR: q_addr_reg[q_idx] <= avs_writedata_i;
                    `TQT_W_MISC: q_misc_reg[q_idx] <= avs_writedata_i;
                    default:     q_port_reg[q_idx] <= avs_writedata_i;
                endcase
            end else if (!q_sel) begin
                case (avs_address_i)
                    `TQT_CTRL:    ctrl_reg <= avs_writedata_i[6:0];
                    `TQT_TPOS:    tpos_reg <= avs_writedata_i[14:0];
                    `TQT_LOOP:    loop_reg <= avs_writedata_i[15:0];
                    `TQT_IRQ_ENA: irq_ena_reg <= avs_writedata_i[2:0];
                    default:      ;
                endcase
            end
        end
    end

    // Trigger taken on the pass the loop count picks
    assign fire = state_reg[1] & frame_valid_i & trigger_select_hit
                & (loop_cnt_reg == loop_reg); // RQ6
    assign last_post = state_reg[2] & frame_valid_i & cap_ok & int_ok
                     & (post_left_reg == 15'h0001);

    // Capture sequencer
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_reg     <= ST_IDLE;
            loop_cnt_reg  <= 16'h0000;
            pre_cnt_reg   <= 15'h0000;
            post_left_reg <= 15'h0000;
            got_a_reg     <= 1'b0;
            got_b_reg     <= 1'b0;
            stopped_reg   <= 1'b0;
        end else if (start_cmd) begin
            state_reg     <= ST_PRE;
            loop_cnt_reg  <= 16'h0000;
            pre_cnt_reg   <= 15'h0000;
            post_left_reg <= 15'h0000;
            got_a_reg     <= 1'b0;
            got_b_reg     <= 1'b0;
            stopped_reg   <= 1'b0;
        end else if (stop_cmd & running) begin
            state_reg   <= ST_DONE;
            stopped_reg <= 1'b1;
        end else begin
            if (running & frame_valid_i) begin
                got_a_reg <= got_a_reg | any_a;
                got_b_reg <= got_b_reg | any_b;
            end
            case (state_reg)
                ST_PRE: begin
                    if (frame_valid_i & cap_ok & int_ok
                        & (pre_cnt_reg < `TQT_DEPTH - tpos_reg)) begin
                        pre_cnt_reg <= pre_cnt_reg + 15'h0001;  // RQ5
                    end
                    if (fire) begin
                        if (tpos_reg <= 15'h0001) begin
                            state_reg <= ST_DONE;
                        end else begin
                            state_reg <= ST_POST;
                        end
                        post_left_reg <= tpos_reg
                                       - {14'h0000, |tpos_reg}; // RQ5
                    end else if (frame_valid_i & trigger_select_hit) begin
                        loop_cnt_reg <= loop_cnt_reg + 16'h0001; // RQ6
                    end
                end
                ST_POST: begin
                    if (frame_valid_i & cap_ok & int_ok) begin
                        post_left_reg <= post_left_reg - 15'h0001;
                    end
                    if (last_post) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_IDLE: state_reg <= ST_IDLE;
                ST_DONE: state_reg <= ST_DONE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Frame store strobe and trigger pulse
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            store_reg      <= 1'b0;
            store_post_reg <= 1'b0;
            trigger_select_reg       <= 1'b0;
        end else begin
            store_reg      <= running & frame_valid_i
                            & cap_ok & int_ok; // RQ1 RQ4
            store_post_reg <= state_reg[2] | fire;
            trigger_select_reg       <= fire; // RQ3
        end
    end

    // Break holds while the enable stays on
    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            brk_reg <= 1'b0;
        end else if (!ctrl_reg[`TQT_C_BRK]) begin
            brk_reg <= 1'b0;
        end else if (frame_valid_i & (any_a | any_b)) begin
            brk_reg <= 1'b1; // RQ7
        end
    end

    // Sticky interrupt status, set wins over clear
    assign irq_set = {ctrl_reg[`TQT_C_BRK] & frame_valid_i
                      & (any_a | any_b),
                      last_post | (fire & (tpos_reg <= 15'h0001)),
                      fire};

    always @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            irq_stat_reg <= 3'h0;
        end else if (wr_go & !q_sel & (avs_address_i == `TQT_IRQ_CLR)) begin
            irq_stat_reg <= (irq_stat_reg & ~avs_writedata_i[2:0])
                          | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    assign irq_o        = |(irq_stat_reg & irq_ena_reg);
    assign store_o      = store_reg;
    assign store_post_o = store_post_reg;
    assign trigger_o    = trigger_select_reg;
    assign capturing_o  = running;
    assign break_o      = brk_reg;
endmodule

`default_nettype wire

// [sim/tqt_top_assertions.sv]
// Checker: bus handshake, trigger, store, break.
// Assumes a bind into tqt_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tqt_top_assertions (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic frame_valid_i,
    input wire logic store_o,
    input wire logic store_post_o,
    input wire logic trigger_o,
    input wire logic capturing_o,
    input wire logic break_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ack;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    a_wait_first: assert property ((avs_read_i || avs_write_i)
        && !$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait state");
    a_wait_one: assert property (s_req |=> s_ack)
        else $error("late answer");
    a_trigger_select_pulse: assert property (trigger_o |=> !trigger_o)
        else $error("long trigger");
    a_trigger_select_cause: assert property (trigger_o |->
        $past(frame_valid_i) && $past(capturing_o))
        else $error("stray trigger");
    a_trigger_select_post: assert property (trigger_o |-> store_post_o)
        else $error("trigger not post");
    a_store_cause: assert property (store_o |->
        $past(frame_valid_i) && $past(capturing_o))
        else $error("stray store");
    a_break_rise: assert property ($rose(break_o) |->
        $past(frame_valid_i))
        else $error("stray break");
    a_break_fall: assert property ($fell(break_o) |->
        $past(avs_write_i) || $past(avs_write_i, 2))
        else $error("break fell early");
endmodule
`default_nettype wire

// [sim/tqt_cpu_model.sv]
// Processor bus model: one frame per call, then inverted lines.
// Assumes calls begin just after a falling edge of the system clock.
`timescale 1ns/10ps
`default_nettype none
module tqt_cpu_model (
    input  wire logic       clk_sys_i,
    output logic            frame_valid_o,
    output logic [15:0]     frame_addr_o,
    output logic [7:0]      frame_data_o,
    output logic [2:0]      flags_o,
    output logic [2:0]      int_level_o,
    output logic [1:0]      probe_o,
    output logic [7:0]      port1_o,
    output logic [7:0]      port3_o
);
    initial {frame_valid_o, frame_addr_o, frame_data_o, flags_o,
        int_level_o, probe_o, port1_o, port3_o} = '0;
    // Probes settle before the frame that uses them
    task automatic send_frame(input logic [15:0] a, m,
                              input logic [7:0]  p1, p3);
        @(posedge clk_sys_i);
        if (probe_o !== m[12:11]) begin
            probe_o <= m[12:11];
            repeat (6) @(posedge clk_sys_i);
        end
        frame_valid_o <= 1'b1;
        {frame_addr_o, flags_o, int_level_o, frame_data_o} <=
            {a, m[15:13], m[10:8], m[7:0]};
        {port3_o, port1_o} <= {p3, p1};
        @(posedge clk_sys_i);
        frame_valid_o <= 1'b0;
        {frame_addr_o, flags_o, int_level_o, frame_data_o, port1_o,
            port3_o} <= ~{frame_addr_o, flags_o, int_level_o,
            frame_data_o, port1_o, port3_o};
    endtask
endmodule
`default_nettype wire

// [sim/tb_tqt_top.sv]
// Random self-checking bench of the trace qualifier.
// Assumes the design under verilog/ and the processor bus model.
`timescale 1ns/10ps
`default_nettype none
`include "tqt_regs.vh"
module tb_tqt_top;
    logic        clk_sys_i       = 1'b0;
    logic        reset_n_i       = 1'b0;
    logic [9:0]  avs_address_i   = 10'h000;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    wire  [31:0] avs_readdata_o;
    wire         avs_waitrequest_o, frame_valid_i, probe_input_one_i;
    wire  [15:0] frame_addr_i;
    wire  [7:0]  frame_data_i, port_byte_one_i, port_byte_three_i;
    wire  [2:0]  flags, frame_int_level_i;
    wire  [1:0]  probes;
    wire         probe_input_zero_i, store_o, store_post_o, trigger_o;
    wire         capturing_o, break_o, irq_o;
    integer      seed = 8;
    int          err_total = 0;
    int          total_checks = 0;
    int          q, pq;
    logic [31:0] rd, r, b, c, e;
    logic [31:0] qw [0:3];
    logic [15:0] fa, fm, fp;
    logic [15:0] ca [0:3] = '{16'h3FFF, 16'h4000, 16'h5000, 16'h5001};
    assign {probe_input_one_i, probe_input_zero_i} = probes;
    tqt_top tqt_top_inst (.clk_sys_i, .reset_n_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
        .avs_waitrequest_o, .frame_valid_i, .frame_addr_i, .frame_data_i,
        .first_opcode_fetch_flag_i(flags[2]), .frame_write_i(flags[1]),
        .frame_read_i(flags[0]), .frame_int_level_i, .probe_input_one_i,
        .probe_input_zero_i, .port_byte_one_i, .port_byte_three_i,
        .store_o, .store_post_o, .trigger_o, .capturing_o, .break_o,
        .irq_o);
    tqt_cpu_model tqt_cpu_model_inst (.clk_sys_i,
        .frame_valid_o(frame_valid_i), .frame_addr_o(frame_addr_i),
        .frame_data_o(frame_data_i), .flags_o(flags),
        .int_level_o(frame_int_level_i), .probe_o(probes),
        .port1_o(port_byte_one_i), .port3_o(port_byte_three_i));
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task give_verdict;
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus master: hold the request until waitrequest is low
    task av(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {avs_address_i, avs_write_i, avs_read_i} <= {a, wr, !wr};
        avs_writedata_i <= d;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'b00;
        @(negedge clk_sys_i);
    endtask
    task qset(input int k);
        for (int i = 0; i < 4; i++)
            av(1'b1, 10'h200 + 10'(k * 16 + i * 4), qw[i]);
    endtask
    task fr(input logic [15:0] a, m, p, input logic [2:0] x);
        tqt_cpu_model_inst.send_frame(a, m, p[7:0], p[15:8]);
        @(negedge clk_sys_i);
        check("outputs", {29'h0, trigger_o, store_post_o, store_o},
            {29'h0, x});
    endtask
    function automatic logic qmatch(input logic [15:0] a, m, p);
        logic am;
        am = qw[0][1] ? (a >= qw[1][15:0] && a <= qw[1][31:16])
                      : (((a ^ qw[1][15:0]) & qw[1][31:16]) == 16'h0);
        return qw[0][0] && am && (((m ^ qw[2][15:0]) & qw[2][31:16]) == 0)
            && (((p ^ qw[3][15:0]) & qw[3][31:16]) == 16'h0);
    endfunction
    function automatic logic ipass(input logic [1:0] md, input int lv);
        return md == 2'h0 || (md == 2'h1 && lv == 0)
            || (md == 2'h2 && lv != 0);
    endfunction
    initial begin
        repeat (16) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        av(1'b0, `TQT_TPOS, 32'h0);
        check("tpos_reset", rd, {17'h0, 15'(`TQT_DEPTH >> 1)});
        av(1'b0, `TQT_LOOP, 32'h0);
        check("loop_reset", rd, 32'h0);
        av(1'b1, 10'h100, 32'hFFFF_FFFF);
        av(1'b0, 10'h100, 32'h0);
        check("unmapped", rd, 32'h0);
        av(1'b1, `TQT_CMD, 32'h1);
        pq = 0;
        repeat (40) begin
            q = $unsigned($random(seed)) % 20;
            qw[0] = 32'h0;
            qset(pq);
            r = $random(seed);
            b = $random(seed);
            qw[0] = {30'h0, r[0], r[1] | r[2]};
            qw[1] = r[0] ? {b[15:0] + 16'h0040, b[15:0]} : b;
            qw[2] = $random(seed) & $random(seed);
            qw[3] = $random(seed) & $random(seed);
            av(1'b1, `TQT_CTRL, {30'h0, q > 9 || r[3], q < 10 || r[3]});
            qset(q);
            pq = q;
            repeat (4) begin
                {b, c, e} = {$random(seed), $random(seed), $random(seed)};
                fa = qw[0][1] ? qw[1][15:0] + {9'h0, b[6:0]} - 16'h0008
                    : qw[1][15:0] ^ (b[15:0] & ~qw[1][31:16])
                      ^ ({16{e[1:0] == 2'h0}} & e[31:16]);
                fm = qw[2][15:0] ^ (b[31:16] & ~qw[2][31:16])
                    ^ ({16{e[3:2] == 2'h0}} & e[15:0]);
                fp = qw[3][15:0] ^ (c[15:0] & ~qw[3][31:16])
                    ^ ({16{e[5:4] == 2'h0}} & c[31:16]);
                fr(fa, fm, fp, {2'b00, qmatch(fa, fm, fp)});
            end
        end
        qw[0] = 32'h0;
        qset(pq);
        qw = '{32'h3, 32'h5000_4000, 32'h0, 32'h0};
        qset(19);
        av(1'b1, `TQT_CTRL, 32'h2);
        foreach (ca[i])
            fr(ca[i], 16'h0, 16'h0, {2'b00, qmatch(ca[i], 0, 0)});
        for (int md = 0; md < 3; md++) begin
            av(1'b1, `TQT_CTRL, 32'(md << 4));
            for (int lv = 0; lv < 8; lv += 5)
                fr(16'h0100, 16'(lv << 8), 16'h0, {2'b00, ipass(md[1:0], lv)});
        end
        av(1'b1, `TQT_CMD, 32'h2);
        qw[0] = 32'h0;
        qset(19);
        qw = '{32'h1, 32'hFFFF_1234, 32'h0, 32'h0};
        qset(0);
        av(1'b1, `TQT_TPOS, 32'h2);
        av(1'b1, `TQT_LOOP, 32'h1);
        av(1'b0, `TQT_TPOS, 32'h0);
        check("tpos_rw", rd, 32'h2);
        for (int s = 0; s < 4; s++) begin
            av(1'b1, `TQT_CTRL, 32'(s << 2));
            av(1'b1, `TQT_CMD, 32'h1);
            fr(16'h1234, 16'h0, 16'h0, 3'b001);
            fr(16'h1234, 16'h0, 16'h0, {s[0], s[0], 1'b1});
            fr(16'h0001, 16'h0, 16'h0, {1'b0, s[0], 1'b1});
            check("capturing", {31'h0, capturing_o}, {31'h0, !s[0]});
            if (s == 1) begin
                av(1'b0, `TQT_IRQ_STAT, 32'h0);
                check("irq_stat", rd & 32'h3, 32'h3);
                check("irq_masked", {31'h0, irq_o}, 32'h0);
                av(1'b1, `TQT_IRQ_ENA, 32'h3);
                check("irq_on", {31'h0, irq_o}, 32'h1);
                av(1'b1, `TQT_IRQ_CLR, 32'h3);
                check("irq_clear", {31'h0, irq_o}, 32'h0);
            end
            av(1'b1, `TQT_CMD, 32'h2);
        end
        av(1'b1, `TQT_CTRL, 32'h40);
        fr(16'h0001, 16'h0, 16'h0, 3'b000);
        check("break_miss", {31'h0, break_o}, 32'h0);
        fr(16'h1234, 16'h0, 16'h0, 3'b000);
        check("break_hit", {31'h0, break_o}, 32'h1);
        qw[0] = 32'h0;
        qset(0);
        check("break_held", {31'h0, break_o}, 32'h1);
        av(1'b1, `TQT_CTRL, 32'h0);
        repeat (2) @(negedge clk_sys_i);
        check("break_off", {31'h0, break_o}, 32'h0);
        av(1'b1, `TQT_CTRL, 32'h40);
        fr(16'h1234, 16'h0, 16'h0, 3'b000);
        check("break_inactive", {31'h0, break_o}, 32'h0);
        give_verdict;
    end
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        err_total++;
        give_verdict;
    end
endmodule
bind tqt_top tqt_top_assertions tqt_top_assertions_inst (.clk_sys_i,
    .reset_n_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .frame_valid_i, .store_o, .store_post_o, .trigger_o, .capturing_o,
    .break_o);
`default_nettype wire
